// ===== logic/twrd_map.svh
// Constants for the two-wire run and direction decoder
`ifndef TWRD_MAP_SVH
`define TWRD_MAP_SVH

`define TWRD_SEL_W          3
`define TWRD_NUM_DI         8
`define TWRD_MACRO_W        8
`define TWRD_MACRO_TWO_WIRE 8'h0c
`define TWRD_DI_RUN         3'h0
`define TWRD_DI_REV         3'h1
`define TWRD_DI_CMD1        3'h0
`define TWRD_DI_CMD2        3'h1
`define TWRD_SCHEME_ONOFF   1'b0
`define TWRD_SCHEME_CWCCW   1'b1
`define TWRD_MACRO_RST      8'h00
`define TWRD_SEL_RST        3'h0
`define TWRD_SYNC_STAGES    3

`endif

// ===== logic/twrd_pkg.sv
// Types for the two-wire run and direction decoder
`include "twrd_map.svh"

package twrd_pkg;

	typedef enum logic [1:0] {
		TWRD_STOP = 2'b00,
		TWRD_CW   = 2'b01,
		TWRD_CCW  = 2'b10
	} twrd_state_t;

	typedef struct packed {
		logic                     scheme;
		logic [`TWRD_MACRO_W-1:0] macro_select;
		logic [`TWRD_SEL_W-1:0]   run_cmd_source_sel;
		logic [`TWRD_SEL_W-1:0]   reverse_source_sel;
		logic [`TWRD_SEL_W-1:0]   wire_cmd1_source_sel;
		logic [`TWRD_SEL_W-1:0]   wire_cmd2_source_sel;
	} twrd_cfg_t;

	typedef struct packed {
		logic run;
		logic ccw;
		logic ramp_stop;
	} twrd_drive_t;

endpackage : twrd_pkg

// ===== logic/twrd_di_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module twrd_di_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] state_q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else begin
					s1_q <= pin[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// Level only taken once two late stages agree
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					state_q[i] <= 1'b0;
				end else if (s2_q == s3_q) begin
					state_q[i] <= s3_q;
				end
			end
		end
	endgenerate

endmodule : twrd_di_sync

// ===== logic/twrd_decoder.sv
// Two-wire run/stop and direction decoder for a motor converter
`timescale 1ns/1ps
`include "twrd_map.svh"

// Operation
// - Scheme one: a low run command ramps to a stop, whatever reverse is.
// - Scheme one: high run turns clockwise, or anticlockwise with reverse.
// - Scheme two: cw alone runs cw, ccw alone runs ccw, both low ramp stop.
// - Scheme two: with both commands high the first to rise sets direction.
// - Scheme two: a start from stop waits until the motor is at standstill.
// - Macro setting twelve maps input 0 to run and input 1 to reverse.
// - Run and reverse sources are each selectable from any digital input.
// - The cw and ccw sources are each selectable from any digital input.
module twrd_decoder
	import twrd_pkg::*;
#(
	parameter int NUM_DI = `TWRD_NUM_DI
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [NUM_DI-1:0] digital_input,
	input  wire logic              motor_standstill,
	input  wire twrd_cfg_t         cfg,
	output twrd_drive_t            drive_q,
	output twrd_state_t            state_q,
	output logic                   scheme_q
);

	logic [NUM_DI-1:0] di_q;
	twrd_cfg_t         cfg_q;
	twrd_state_t       st_d;
	logic              cfg_chg;
	logic              macro_on;
	logic [`TWRD_SEL_W-1:0] run_src;
	logic [`TWRD_SEL_W-1:0] rev_src;
	logic [`TWRD_SEL_W-1:0] cw_src;
	logic [`TWRD_SEL_W-1:0] ccw_src;
	logic              run_cmd;
	logic              rev_cmd;
	logic              cw_cmd;
	logic              ccw_cmd;
	logic              cw_prev_q;
	logic              ccw_prev_q;
	logic              ccw_first_q;

	function automatic logic pick_bit(
		input logic [NUM_DI-1:0]      v,
		input logic [`TWRD_SEL_W-1:0] s
	);
		pick_bit = v[s];
	endfunction : pick_bit

	twrd_di_sync #(
		.WIDTH (NUM_DI)
	) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.pin     (digital_input),
		.state_q (di_q)
	);

	// Configuration held so a scheme change is seen as one event
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_q <= '{scheme: `TWRD_SCHEME_ONOFF,
				macro_select: `TWRD_MACRO_RST,
				run_cmd_source_sel: `TWRD_SEL_RST,
				reverse_source_sel: `TWRD_SEL_RST,
				wire_cmd1_source_sel: `TWRD_SEL_RST,
				wire_cmd2_source_sel: `TWRD_SEL_RST};
		end else begin
			cfg_q <= cfg;
		end
	end

	assign cfg_chg  = (cfg.scheme != cfg_q.scheme);
	assign macro_on = (cfg_q.macro_select == `TWRD_MACRO_TWO_WIRE);

	// Macro overrides the individual selectors
	assign run_src = macro_on ? `TWRD_DI_RUN
		: cfg_q.run_cmd_source_sel;
	assign rev_src = macro_on ? `TWRD_DI_REV
		: cfg_q.reverse_source_sel;
	assign cw_src  = macro_on ? `TWRD_DI_CMD1
		: cfg_q.wire_cmd1_source_sel;
	assign ccw_src = macro_on ? `TWRD_DI_CMD2
		: cfg_q.wire_cmd2_source_sel;

	assign run_cmd = pick_bit(di_q, run_src);
	assign rev_cmd = pick_bit(di_q, rev_src);
	assign cw_cmd  = pick_bit(di_q, cw_src);
	assign ccw_cmd = pick_bit(di_q, ccw_src);

	// Which command rose first; a tie goes to clockwise
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cw_prev_q   <= 1'b0;
			ccw_prev_q  <= 1'b0;
			ccw_first_q <= 1'b0;
		end else begin
			cw_prev_q  <= cw_cmd;
			ccw_prev_q <= ccw_cmd;
			if (cw_cmd && !cw_prev_q && !(ccw_cmd && ccw_prev_q)) begin
				ccw_first_q <= 1'b0;
			end else if (ccw_cmd && !ccw_prev_q && !cw_cmd) begin
				ccw_first_q <= 1'b1;
			end
		end
	end

	always_comb begin
		st_d = state_q;
		if (cfg_chg) begin
			st_d = TWRD_STOP;
		end else if (cfg_q.scheme == `TWRD_SCHEME_ONOFF) begin
			if (!run_cmd) begin
				st_d = TWRD_STOP;
			end else begin
				st_d = rev_cmd ? TWRD_CCW : TWRD_CW;
			end
		end else begin
			unique case (state_q)
				TWRD_STOP: begin
					// Restart only from rest, never reversing at speed
					if (motor_standstill) begin
						if (cw_cmd && ccw_cmd) begin
							st_d = ccw_first_q ? TWRD_CCW : TWRD_CW;
						end else if (cw_cmd) begin
							st_d = TWRD_CW;
						end else if (ccw_cmd) begin
							st_d = TWRD_CCW;
						end
					end
				end
				TWRD_CW: begin
					if (!cw_cmd) begin
						st_d = TWRD_STOP;
					end
				end
				TWRD_CCW: begin
					if (!ccw_cmd) begin
						st_d = TWRD_STOP;
					end
				end
				default: begin
					st_d = TWRD_STOP;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= TWRD_STOP;
		end else begin
			state_q <= st_d;
		end
	end

	// Direction holds its last value while stopped
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			drive_q <= '{run: 1'b0, ccw: 1'b0, ramp_stop: 1'b1};
		end else begin
			drive_q.run       <= (st_d != TWRD_STOP);
			drive_q.ramp_stop <= (st_d == TWRD_STOP);
			if (st_d == TWRD_CCW) begin
				drive_q.ccw <= 1'b1;
			end else if (st_d == TWRD_CW) begin
				drive_q.ccw <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scheme_q <= `TWRD_SCHEME_ONOFF;
		end else begin
			scheme_q <= cfg_q.scheme;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_m1_stop_any: assert property (
		cfg_q.scheme == `TWRD_SCHEME_ONOFF && !cfg_chg && !run_cmd
		|=> !drive_q.run && drive_q.ramp_stop)
		else $error("scheme one did not stop on low run");

	a_m1_dir_follow: assert property (
		cfg_q.scheme == `TWRD_SCHEME_ONOFF && !cfg_chg && run_cmd
		|=> drive_q.run && drive_q.ccw == $past(rev_cmd))
		else $error("scheme one direction wrong");

	a_m2_start_cw: assert property (
		cfg_q.scheme == `TWRD_SCHEME_CWCCW && !cfg_chg
		&& state_q == TWRD_STOP && motor_standstill && cw_cmd && !ccw_cmd
		|=> state_q == TWRD_CW ##0 drive_q.run && !drive_q.ccw)
		else $error("scheme two did not start clockwise");

	a_m2_both_low: assert property (
		cfg_q.scheme == `TWRD_SCHEME_CWCCW && !cfg_chg && !cw_cmd && !ccw_cmd
		|=> state_q == TWRD_STOP && drive_q.ramp_stop)
		else $error("scheme two did not stop with both low");

	a_m2_first_wins: assert property (
		cfg_q.scheme == `TWRD_SCHEME_CWCCW && !cfg_chg
		&& state_q == TWRD_CCW && ccw_cmd && cw_cmd
		|=> state_q == TWRD_CCW)
		else $error("scheme two lost first direction");

	a_m2_wait_rest: assert property (
		cfg_q.scheme == `TWRD_SCHEME_CWCCW && state_q == TWRD_STOP
		&& !motor_standstill
		|=> state_q == TWRD_STOP)
		else $error("scheme two restarted before standstill");

	a_macro_map: assert property (
		macro_on |-> run_cmd == di_q[0] && rev_cmd == di_q[1]
		&& cw_cmd == di_q[0] && ccw_cmd == di_q[1])
		else $error("macro did not map inputs 0 and 1");

	a_src_follow: assert property (
		!macro_on && $stable(cfg_q) && $changed(di_q[cfg_q.run_cmd_source_sel])
		|-> $changed(run_cmd))
		else $error("run source not followed");

	a_cmd_src: assert property (
		!macro_on |-> ccw_cmd == di_q[cfg_q.wire_cmd2_source_sel]
		&& cw_cmd == di_q[cfg_q.wire_cmd1_source_sel])
		else $error("wire command source wrong");

	a_cfg_stop: assert property (
		cfg_chg |=> state_q == TWRD_STOP ##1 scheme_q == $past(cfg.scheme, 2))
		else $error("scheme change did not stop");

	c_m1_reverse: cover property (
		cfg_q.scheme == `TWRD_SCHEME_ONOFF ##1 drive_q.run && drive_q.ccw);
	c_m2_ccw: cover property (
		state_q == TWRD_STOP ##1 state_q == TWRD_CCW);
	c_m2_both: cover property (
		state_q == TWRD_CW && cw_cmd && ccw_cmd [*3]);
	c_cfg_chg: cover property (cfg_chg);

endmodule : twrd_decoder

// ===== tb/twrd_switches.sv
// Switch bank standing for the external command sources
`timescale 1ns/1ps

module twrd_switches #(
	parameter int NUM_DI = 8
) (
	input  wire logic              clk,
	input  wire logic [NUM_DI-1:0] level,
	output logic      [NUM_DI-1:0] digital_input
);
	// Contacts move away from the decoder's sampling edge
	always_ff @(negedge clk) begin
		digital_input <= level;
	end
endmodule : twrd_switches

// ===== tb/testbench.sv
// Self-checking bench for the two-wire run and direction decoder
`timescale 1ns/1ps
`include "twrd_map.svh"

module testbench;
	import twrd_pkg::*;
	logic        clk;
	logic        reset_n;
	logic        motor_standstill;
	logic [7:0]  level;
	logic [7:0]  digital_input;
	twrd_cfg_t   cfg;
	twrd_drive_t drive_q;
	twrd_state_t state_q;
	logic        scheme_q;
	int          errors;
	int          checked;

	twrd_switches u_twrd_switches (.clk(clk), .level(level),
		.digital_input(digital_input));
	twrd_decoder u_twrd_decoder (.clk(clk), .reset_n(reset_n),
		.digital_input(digital_input), .motor_standstill(motor_standstill),
		.cfg(cfg), .drive_q(drive_q), .state_q(state_q), .scheme_q(scheme_q));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// Sync plus decode takes five edges; nine leaves margin
	task automatic apply(input logic [7:0] lv, input logic ss);
		level <= lv;
		motor_standstill <= ss;
		repeat (9) @(negedge clk);
	endtask : apply

	// Ccw expectation is passed in, as it holds while stopped
	task automatic expect_st(input twrd_state_t st, input logic ccw);
		logic run;
		run = (st != TWRD_STOP);
		check({3'h0, state_q, drive_q}, {3'h0, st, run, ccw, ~run});
	endtask : expect_st

	task automatic s_scheme_one;
		logic [1:0]  tab [6];
		logic        ccw;
		twrd_state_t st;
		tab = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b01, 2'b00};
		ccw = 1'b0;
		cfg.run_cmd_source_sel <= 3'h3;
		cfg.reverse_source_sel <= 3'h5;
		for (int i = 0; i < 6; i++) begin
			// Decoy levels on inputs 0 and 1 catch a stuck selector
			apply({2'b00, tab[i][0], 1'b0, tab[i][1], 1'b0, ~tab[i]}, 1'b0);
			if (tab[i][1])
				ccw = tab[i][0];
			st = tab[i][1] ? (ccw ? TWRD_CCW : TWRD_CW) : TWRD_STOP;
			expect_st(st, ccw);
		end
	endtask : s_scheme_one

	task automatic s_macro;
		cfg.macro_select <= `TWRD_MACRO_TWO_WIRE;
		apply(8'h03, 1'b0);
		expect_st(TWRD_CCW, 1'b1);
		apply(8'h28, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		cfg.macro_select <= 8'h00;
	endtask : s_macro

	task automatic s_scheme_two;
		cfg.wire_cmd1_source_sel <= 3'h2;
		cfg.wire_cmd2_source_sel <= 3'h4;
		cfg.scheme <= `TWRD_SCHEME_CWCCW;
		apply(8'h00, 1'b1);
		expect_st(TWRD_STOP, 1'b1);
		check({7'h00, scheme_q}, 8'h01);
		apply(8'h04, 1'b1);
		expect_st(TWRD_CW, 1'b0);
		apply(8'h14, 1'b1);
		expect_st(TWRD_CW, 1'b0);
		apply(8'h10, 1'b0);
		expect_st(TWRD_STOP, 1'b0);
		apply(8'h10, 1'b0);
		expect_st(TWRD_STOP, 1'b0);
		apply(8'h10, 1'b1);
		expect_st(TWRD_CCW, 1'b1);
		apply(8'h14, 1'b1);
		expect_st(TWRD_CCW, 1'b1);
	endtask : s_scheme_two

	// Both high at rest: the earlier riser picks the direction
	task automatic s_first_riser;
		apply(8'h00, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		apply(8'h10, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		apply(8'h14, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		apply(8'h14, 1'b1);
		expect_st(TWRD_CCW, 1'b1);
		apply(8'h00, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		cfg.macro_select <= `TWRD_MACRO_TWO_WIRE;
		apply(8'h01, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		apply(8'h03, 1'b0);
		expect_st(TWRD_STOP, 1'b1);
		apply(8'h03, 1'b1);
		expect_st(TWRD_CW, 1'b0);
		cfg.macro_select <= 8'h00;
	endtask : s_first_riser

	task automatic s_scheme_change;
		cfg.scheme <= `TWRD_SCHEME_ONOFF;
		cfg.run_cmd_source_sel <= 3'h4;
		apply(8'h10, 1'b1);
		expect_st(TWRD_CW, 1'b0);
		check({7'h00, scheme_q}, 8'h00);
	endtask : s_scheme_change

	initial begin
		errors = 0;
		checked = 0;
		level = 8'h00;
		motor_standstill = 1'b0;
		cfg = '0;
		reset_n = 1'b0;
		repeat (5) @(negedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		expect_st(TWRD_STOP, 1'b0);
		s_scheme_one();
		s_macro();
		s_scheme_two();
		s_first_riser();
		s_scheme_change();
		final_report();
	end

	// About 220 cycles of tests; cut a hang well beyond that
	initial begin
		#50000;
		errors++;
		final_report();
	end
endmodule : testbench
